// file: hw/crt_regs.sv
// Implementation choice: the strobed register port.
`include "crt_consts.svh"
// Behaviour
// RL1: user clip reads zero outside fields
// RL2: user clip fields survive reset
// RL3: system clip reads zero outside fields
// RL4: system clip fields survive reset
// RL5: return address split A22-16 / A15-1
// RL6: software writes zero to unused return bits
// RL7: return address survives reset
// RL8: 16bpp offset enabled adds with saturation
// RL9: 8bpp keeps offset enable cleared
// RL10: colour offset holds three signed parts
// RL11: DMA destination word address high/low
// RL12: software leaves DMA address during transfer
// RL13: device clears DMA mode at end
// RL14: mode 11 uses image address, entry data
// RL15: DMA address registers kept, address internal
// RL16: reset zeroes DMA address
// RL17: word count three plus sixteen bits
// RL18: software leaves word count during transfer
// RL19: word count kept, remaining counted internally
// RL20: conversion modes use image address
// RL21: software leaves image address during conversion
// RL22: image address not advanced, reset zero
// RL23: software breaks before reading rendering state
module crt_regs
  import crt_pkg::*;
#(
  parameter int CNT_W = 19
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [10:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        clip_load,
  input  wire logic [13:0] clip_lx,
  input  wire logic [13:0] clip_ty,
  input  wire logic [13:0] clip_rx,
  input  wire logic [13:0] clip_by,
  input  wire logic [13:0] sclip_rx,
  input  wire logic [13:0] sclip_by,
  input  wire logic        rtn_load,
  input  wire logic [21:0] rtn_addr,
  input  wire logic        img_wr,
  input  wire logic [15:0] img_data,
  input  wire logic        conv_done,
  input  wire logic        mem_ready,
  input  wire logic [15:0] src_pixel,
  output logic      [15:0] pixel_out,
  output logic             mem_wr,
  output logic      [21:0] mem_addr,
  output logic      [15:0] mem_data,
  output logic             dma_req
);
  if (CNT_W != 19) begin : g_cnt_w_chk
    $error("CNT_W must be 19");
  end

  // ----------------------------------------------------------------
  // Rendering state (no reset)
  // ----------------------------------------------------------------
  logic [13:0] uc_lx_ff, uc_ty_ff, uc_rx_ff, uc_by_ff, sc_rx_ff, sc_by_ff;
  logic [6:0]  rtn_hi_ff;
  logic [14:0] rtn_lo_ff;
  logic [15:0] color_ff;
  logic [13:0] nxt_uc_lx, nxt_uc_ty, nxt_uc_rx, nxt_uc_by;
  logic [13:0] nxt_sc_rx, nxt_sc_by;
  logic [6:0]  nxt_rtn_hi;
  logic [14:0] nxt_rtn_lo;
  logic [15:0] nxt_color;
  logic        wr_rtn_hi, wr_color;

  assign wr_rtn_hi = wr && addr == `CRT_OFS_RTN_HI;
  assign wr_color  = wr && addr == `CRT_OFS_COLOR_OFS;

  always_comb begin
    nxt_uc_lx = clip_load ? clip_lx : uc_lx_ff;
    nxt_uc_ty = clip_load ? clip_ty : uc_ty_ff;
    nxt_uc_rx = clip_load ? clip_rx : uc_rx_ff;
    nxt_uc_by = clip_load ? clip_by : uc_by_ff;
    nxt_sc_rx = clip_load ? sclip_rx : sc_rx_ff;
    nxt_sc_by = clip_load ? sclip_by : sc_by_ff;
    nxt_rtn_hi = rtn_hi_ff;
    nxt_rtn_lo = rtn_lo_ff;
    if (rtn_load) begin
      nxt_rtn_hi = rtn_addr[21:15];                                 // RL5
      nxt_rtn_lo = rtn_addr[14:0];
    end else if (wr_rtn_hi) begin
      nxt_rtn_hi = wdata[6:0];
    end
    nxt_color = wr_color ? wdata : color_ff;                        // RL10
  end

  // Deliberately no reset term: values persist across reset
  always_ff @(posedge clk) begin                                    // RL2
    uc_lx_ff  <= nxt_uc_lx;
    uc_ty_ff  <= nxt_uc_ty;
    uc_rx_ff  <= nxt_uc_rx;
    uc_by_ff  <= nxt_uc_by;
    sc_rx_ff  <= nxt_sc_rx;                                         // RL4
    sc_by_ff  <= nxt_sc_by;
    rtn_hi_ff <= nxt_rtn_hi;                                        // RL7
    rtn_lo_ff <= nxt_rtn_lo;
    color_ff  <= nxt_color;
  end

  // ----------------------------------------------------------------
  // Transfer control registers (reset to zero)
  // ----------------------------------------------------------------
  logic [6:0]  dma_hi_ff, img_hi_ff, nxt_dma_hi, nxt_img_hi;
  logic [14:0] dma_lo_ff, img_lo_ff, nxt_dma_lo, nxt_img_lo;
  logic [2:0]  cnt_hi_ff, nxt_cnt_hi;
  logic [15:0] cnt_lo_ff, nxt_cnt_lo;
  logic [6:0]  ctrl_ff, nxt_ctrl;
  logic        dma_end;

  always_comb begin
    nxt_dma_hi = dma_hi_ff;
    nxt_dma_lo = dma_lo_ff;
    nxt_img_hi = img_hi_ff;
    nxt_img_lo = img_lo_ff;
    nxt_cnt_hi = cnt_hi_ff;
    nxt_cnt_lo = cnt_lo_ff;
    nxt_ctrl   = ctrl_ff;
    if (wr) begin
      unique case (addr)
        `CRT_OFS_DMA_ADDR_HI: nxt_dma_hi = wdata[6:0];              // RL11
        `CRT_OFS_DMA_ADDR_LO: nxt_dma_lo = wdata[15:1];
        `CRT_OFS_IMG_ADDR_HI: nxt_img_hi = wdata[6:0];
        `CRT_OFS_IMG_ADDR_LO: nxt_img_lo = wdata[15:1];
        `CRT_OFS_DMA_CNT_HI:  nxt_cnt_hi = wdata[2:0];              // RL17
        `CRT_OFS_DMA_CNT_LO:  nxt_cnt_lo = wdata;
        `CRT_OFS_XFER_CTRL:   nxt_ctrl   = wdata[6:0];
        default: ;
      endcase
    end
    // Hardware completion wins over a simultaneous software write
    if (dma_end) begin
      nxt_ctrl[1:0] = 2'h0;                                         // RL13
    end
    if (conv_done) begin
      nxt_ctrl[4:2] = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_hi_ff <= '0;                                              // RL16
      dma_lo_ff <= '0;
      img_hi_ff <= '0;                                              // RL22
      img_lo_ff <= '0;
      cnt_hi_ff <= '0;
      cnt_lo_ff <= '0;
      ctrl_ff   <= '0;
    end else begin
      dma_hi_ff <= nxt_dma_hi;
      dma_lo_ff <= nxt_dma_lo;
      img_hi_ff <= nxt_img_hi;
      img_lo_ff <= nxt_img_lo;
      cnt_hi_ff <= nxt_cnt_hi;
      cnt_lo_ff <= nxt_cnt_lo;
      ctrl_ff   <= nxt_ctrl;
    end
  end

  crt_dma_mode_t dma_mode;
  logic [2:0]    conv_mode;
  logic          conv_active;
  assign dma_mode    = crt_dma_mode_t'(ctrl_ff[1:0]);
  assign conv_mode   = ctrl_ff[4:2];
  assign conv_active = conv_mode == 3'h1 || conv_mode == 3'h2 ||
                       conv_mode == 3'h3 || conv_mode == 3'h7;

  // ----------------------------------------------------------------
  // Transfer engine: running address and count kept internally
  // ----------------------------------------------------------------
  crt_state_t  st_ff, nxt_st;
  logic [21:0] run_addr_ff, nxt_run_addr;
  logic [18:0] remain_ff, nxt_remain;

  always_comb begin
    nxt_st       = st_ff;
    nxt_run_addr = run_addr_ff;
    nxt_remain   = remain_ff;
    dma_end      = 1'b0;
    unique case (st_ff)
      CRT_IDLE: begin
        if (dma_mode == CRT_DMA_RUN) begin
          nxt_st       = CRT_DMA;
          nxt_run_addr = {dma_hi_ff, dma_lo_ff};                    // RL15
          nxt_remain   = {cnt_hi_ff, cnt_lo_ff};                    // RL19
        end else if (dma_mode == CRT_DMA_IMAGE || conv_active) begin
          nxt_st       = CRT_CONV;
          nxt_run_addr = {img_hi_ff, img_lo_ff};                    // RL14 RL20
        end
      end
      CRT_DMA: begin
        if (remain_ff == 19'h0) begin
          dma_end = 1'b1;
          nxt_st  = CRT_IDLE;
        end else if (img_wr && mem_ready) begin
          nxt_run_addr = run_addr_ff + 22'h1;
          nxt_remain   = remain_ff - 19'h1;
        end
      end
      CRT_CONV: begin
        if (conv_done || (dma_mode != CRT_DMA_IMAGE && !conv_active)) begin
          dma_end = dma_mode == CRT_DMA_IMAGE;
          nxt_st  = CRT_IDLE;
        end else if (img_wr && mem_ready) begin
          nxt_run_addr = run_addr_ff + 22'h1;                       // RL22
        end
      end
      default: nxt_st = CRT_IDLE;
    endcase
  end

  logic        nxt_mem_wr;
  logic [21:0] nxt_mem_addr;
  logic [15:0] nxt_mem_data, mem_data_ff;
  logic        mem_wr_ff;
  logic [21:0] mem_addr_ff;
  always_comb begin
    nxt_mem_wr   = (st_ff != CRT_IDLE) && img_wr && mem_ready &&
                   !(st_ff == CRT_DMA && remain_ff == 19'h0);
    nxt_mem_addr = nxt_mem_wr ? run_addr_ff : mem_addr_ff;
    nxt_mem_data = nxt_mem_wr ? img_data : mem_data_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff       <= CRT_IDLE;
      run_addr_ff <= '0;
      remain_ff   <= '0;
      mem_wr_ff   <= 1'b0;
      mem_addr_ff <= '0;
      mem_data_ff <= '0;
    end else begin
      st_ff       <= nxt_st;
      run_addr_ff <= nxt_run_addr;
      remain_ff   <= nxt_remain;
      mem_wr_ff   <= nxt_mem_wr;
      mem_addr_ff <= nxt_mem_addr;
      mem_data_ff <= nxt_mem_data;
    end
  end
  assign mem_wr   = mem_wr_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_data = mem_data_ff;
  assign dma_req  = st_ff == CRT_DMA && remain_ff != 19'h0;

  // ----------------------------------------------------------------
  // Colour offset with saturation, 5:6:5 pixels
  // ----------------------------------------------------------------
  logic [4:0]  sat_r, sat_b;
  logic [5:0]  sat_g;
  logic [15:0] nxt_pixel, pixel_ff;
  crt_sat_add #(.W(5)) u_red (
    .chan (src_pixel[15:11]),
    .ofs  ({color_ff[15], color_ff[15:11]}),
    .sum  (sat_r)
  );
  crt_sat_add #(.W(6)) u_grn (
    .chan (src_pixel[10:5]),
    .ofs  ({color_ff[10], color_ff[10:5]}),
    .sum  (sat_g)
  );
  crt_sat_add #(.W(5)) u_blu (
    .chan (src_pixel[4:0]),
    .ofs  ({color_ff[4], color_ff[4:0]}),
    .sum  (sat_b)
  );
  always_comb begin
    if (ctrl_ff[`CRT_CTRL_COLOR_OFFSET_ENABLE_BIT] && ctrl_ff[`CRT_CTRL_BPP16_BIT]) begin
      nxt_pixel = {sat_r, sat_g, sat_b};                            // RL8
    end else begin
      nxt_pixel = src_pixel;                                        // RL9
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pixel_ff <= '0;
    end else begin
      pixel_ff <= nxt_pixel;
    end
  end
  assign pixel_out = pixel_ff;

  // ----------------------------------------------------------------
  // Read port: data in the cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] rmux, rdata_ff;
  always_comb begin
    rmux = `CRT_RST_ZERO16;
    unique case (addr)
      `CRT_OFS_UCLIP_LX:    rmux = {2'h0, uc_lx_ff};                // RL1
      `CRT_OFS_UCLIP_TY:    rmux = {2'h0, uc_ty_ff};
      `CRT_OFS_UCLIP_RX:    rmux = {2'h0, uc_rx_ff};
      `CRT_OFS_UCLIP_BY:    rmux = {2'h0, uc_by_ff};
      `CRT_OFS_SCLIP_RX:    rmux = {2'h0, sc_rx_ff};                // RL3
      `CRT_OFS_SCLIP_BY:    rmux = {2'h0, sc_by_ff};
      `CRT_OFS_RTN_HI:      rmux = {9'h000, rtn_hi_ff};             // RL6
      `CRT_OFS_RTN_LO:      rmux = {rtn_lo_ff, 1'h0};
      `CRT_OFS_COLOR_OFS:   rmux = color_ff;
      `CRT_OFS_DMA_ADDR_HI: rmux = {9'h000, dma_hi_ff};
      `CRT_OFS_DMA_ADDR_LO: rmux = {dma_lo_ff, 1'h0};
      `CRT_OFS_IMG_ADDR_HI: rmux = {9'h000, img_hi_ff};
      `CRT_OFS_IMG_ADDR_LO: rmux = {img_lo_ff, 1'h0};
      `CRT_OFS_DMA_CNT_HI:  rmux = {13'h0000, cnt_hi_ff};
      `CRT_OFS_DMA_CNT_LO:  rmux = cnt_lo_ff;
      `CRT_OFS_XFER_CTRL:   rmux = {9'h000, ctrl_ff};
      `CRT_OFS_XFER_STAT:   rmux = {15'h0000, st_ff != CRT_IDLE};
      default:              rmux = `CRT_RST_ZERO16;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd ? rmux : `CRT_RST_ZERO16;
    end
  end
  assign rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_dma_start;
    st_ff == CRT_IDLE && dma_mode == CRT_DMA_RUN;
  endsequence
  a_clip_upper_zero: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    rd && addr == `CRT_OFS_UCLIP_LX |=> rdata[15:14] == 2'h0)
    else $error("user clip upper bits not zero");
  a_sclip_upper_zero: assert property (@(posedge clk) disable iff (!arst_n) // RL3
    rd && addr == `CRT_OFS_SCLIP_BY |=> rdata == {2'h0, $past(sc_by_ff)})
    else $error("system clip read wrong");
  a_dma_mode_clear: assert property (@(posedge clk) disable iff (!arst_n) // RL13
    st_ff == CRT_DMA && remain_ff == 19'h0 |=> ctrl_ff[1:0] == 2'h0)
    else $error("dma mode not cleared");
  a_dma_addr_load: assert property (@(posedge clk) disable iff (!arst_n) // RL15
    s_dma_start |=> run_addr_ff == {$past(dma_hi_ff), $past(dma_lo_ff)})
    else $error("dma running address not loaded");
  a_dma_addr_held: assert property (@(posedge clk) disable iff (!arst_n) // RL15
    st_ff == CRT_DMA && !wr |=> $stable(dma_lo_ff))
    else $error("dma address register moved");
  a_count_held: assert property (@(posedge clk) disable iff (!arst_n) // RL19
    st_ff == CRT_DMA && !wr |=> $stable(cnt_lo_ff) && $stable(cnt_hi_ff))
    else $error("word count register moved");
  a_img_start: assert property (@(posedge clk) disable iff (!arst_n) // RL14
    st_ff == CRT_IDLE && dma_mode == CRT_DMA_IMAGE
    |=> st_ff == CRT_CONV && run_addr_ff == {$past(img_hi_ff), $past(img_lo_ff)})
    else $error("image transfer start wrong");
  a_img_addr_fixed: assert property (@(posedge clk) disable iff (!arst_n) // RL22
    st_ff == CRT_CONV && !wr |=> $stable(img_lo_ff) && $stable(img_hi_ff))
    else $error("image address register moved");
  a_offset_bypass: assert property (@(posedge clk) disable iff (!arst_n) // RL8
    !ctrl_ff[`CRT_CTRL_COLOR_OFFSET_ENABLE_BIT] |=> pixel_out == $past(src_pixel))
    else $error("pixel altered with offset off");
endmodule

// file: hw/crt_consts.svh
`ifndef CRT_CONSTS_SVH
`define CRT_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the 16-bit port)
// ----------------------------------------------------------------
`define CRT_OFS_DMA_ADDR_HI   11'h020
`define CRT_OFS_DMA_ADDR_LO   11'h022
`define CRT_OFS_IMG_ADDR_HI   11'h042
`define CRT_OFS_IMG_ADDR_LO   11'h044
`define CRT_OFS_DMA_CNT_HI    11'h050
`define CRT_OFS_DMA_CNT_LO    11'h052
`define CRT_OFS_UCLIP_LX      11'h088
`define CRT_OFS_UCLIP_TY      11'h08A
`define CRT_OFS_UCLIP_RX      11'h08C
`define CRT_OFS_UCLIP_BY      11'h08E
`define CRT_OFS_SCLIP_RX      11'h090
`define CRT_OFS_SCLIP_BY      11'h092
`define CRT_OFS_RTN_HI        11'h094
`define CRT_OFS_RTN_LO        11'h096
`define CRT_OFS_COLOR_OFS     11'h09A
`define CRT_OFS_XFER_CTRL     11'h0A0
`define CRT_OFS_XFER_STAT     11'h0A2
// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CRT_CLIP_W            14
`define CRT_ADDR_HI_W         7
`define CRT_CNT_HI_W          3
`define CRT_CTRL_DMA_LSB      0
`define CRT_CTRL_CONV_LSB     2
`define CRT_CTRL_COLOR_OFFSET_ENABLE_BIT     5
`define CRT_CTRL_BPP16_BIT    6
`define CRT_STAT_BUSY_BIT     0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRT_RST_ZERO16        16'h0000
`endif

// file: hw/crt_pkg.sv
package crt_pkg;
  typedef enum logic [1:0] {
    CRT_DMA_OFF   = 2'h0,
    CRT_DMA_RUN   = 2'h1,
    CRT_DMA_RSVD  = 2'h2,
    CRT_DMA_IMAGE = 2'h3
  } crt_dma_mode_t;
  typedef enum logic [1:0] {
    CRT_IDLE,
    CRT_DMA,
    CRT_CONV
  } crt_state_t;
endpackage

// file: hw/crt_sat_add.sv
// Signed offset added to an unsigned channel, clamped to 0..max
module crt_sat_add #(
  parameter int W = 5
) (
  input  wire logic [W-1:0] chan,
  input  wire logic [W:0]   ofs,
  output logic      [W-1:0] sum
);
  logic signed [W+1:0] wide;
  always_comb begin
    wide = $signed({2'h0, chan}) + $signed({ofs[W], ofs});
    if (wide < 0) begin
      sum = '0;
    end else if (wide[W]) begin
      sum = '1;
    end else begin
      sum = wide[W-1:0];
    end
  end
endmodule

// file: verif/crt_mem_model.sv
// ----------------------------------------------------------------
// Graphics memory write port: accepts at once, or stalls after each
// write for three cycles when slow is set
// ----------------------------------------------------------------
module crt_mem_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic slow,
  input  wire logic mem_wr,
  output logic      mem_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;

  always_comb begin
    nxt_wait = wait_ff;
    if (mem_wr && slow) begin
      nxt_wait = 2'h3;
    end else if (wait_ff != 2'h0) begin
      nxt_wait = wait_ff - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= nxt_wait;
    end
  end

  assign mem_ready = (wait_ff == 2'h0);
endmodule

// file: verif/tb_top.sv
`include "crt_consts.svh"
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((e) !== (g)) begin \
      num_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, arst_n, wr, rd, clip_load, rtn_load, slow;
  logic        img_wr, conv_done, mem_ready, mem_wr, dma_req;
  logic [10:0] addr;
  logic [15:0] wdata, rdata, img_data, src_pixel, pixel_out, mem_data;
  logic [13:0] clip_lx, clip_ty, clip_rx, clip_by, sclip_rx, sclip_by;
  logic [21:0] rtn_addr, mem_addr;
  int          num_errors, comparisons, cycles;

  localparam logic [10:0] XO [6] = '{`CRT_OFS_DMA_ADDR_HI,
    `CRT_OFS_DMA_ADDR_LO, `CRT_OFS_IMG_ADDR_HI, `CRT_OFS_IMG_ADDR_LO,
    `CRT_OFS_DMA_CNT_HI, `CRT_OFS_DMA_CNT_LO};
  localparam logic [15:0] XM [6] = '{16'h007F, 16'hFFFE, 16'h007F,
    16'hFFFE, 16'h0007, 16'hFFFF};
  localparam logic [15:0] XV [6] = '{16'h0055, 16'hABCE, 16'h0012,
    16'h3456, 16'h0000, 16'h0003};
  localparam logic [13:0] CV [6] = '{14'h2ABC, 14'h1234, 14'h3FFF,
    14'h0001, 14'h2000, 14'h1FFF};
  localparam logic [21:0] RTN = 22'h2ABCDE;

  crt_regs #(.CNT_W(19)) i_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clip_load(clip_load), .clip_lx(clip_lx),
    .clip_ty(clip_ty), .clip_rx(clip_rx), .clip_by(clip_by),
    .sclip_rx(sclip_rx), .sclip_by(sclip_by), .rtn_load(rtn_load),
    .rtn_addr(rtn_addr), .img_wr(img_wr), .img_data(img_data),
    .conv_done(conv_done), .mem_ready(mem_ready), .src_pixel(src_pixel),
    .pixel_out(pixel_out), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_data(mem_data), .dma_req(dma_req));

  crt_mem_model i_mem (
    .clk(clk), .arst_n(arst_n), .slow(slow), .mem_wr(mem_wr),
    .mem_ready(mem_ready));

  // ----------------------------------------------------------------
  // Bus and check tasks, called just after a rising edge
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [10:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_rd(input logic [10:0] a, input logic [15:0] e,
                        input logic [15:0] m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK($sformatf("reg %h", a), e & m, rdata & m)
    @(posedge clk);
  endtask

  task automatic chk_xfer(input bit zero);
    for (int i = 0; i < 6; i++) begin
      chk_rd(XO[i], zero ? 16'h0000 : XV[i], XM[i]);
    end
  endtask

  task automatic chk_state();
    for (int i = 0; i < 6; i++) begin
      chk_rd(`CRT_OFS_UCLIP_LX + 11'(2 * i), {2'h0, CV[i]}, 16'hFFFF);
    end
    chk_rd(`CRT_OFS_RTN_HI, {9'h000, RTN[21:15]}, 16'h007F);
    chk_rd(`CRT_OFS_RTN_LO, {RTN[14:0], 1'h0}, 16'hFFFE);
  endtask

  task automatic send_words(input int n, input logic [21:0] base,
                            input bit chk_data);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      while (!mem_ready) @(negedge clk);
      @(posedge clk);
      img_wr <= 1'b1;
      img_data <= 16'hC000 + 16'(i);
      @(posedge clk);
      img_wr <= 1'b0;
      @(negedge clk);
      `CHK("mem_wr", 1'b1, mem_wr)
      `CHK("mem_addr", base + 22'(i), mem_addr)
      if (chk_data) `CHK("mem_data", 16'hC000 + 16'(i), mem_data)
    end
    @(posedge clk);
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    {arst_n, wr, rd, clip_load, rtn_load, img_wr, conv_done} = '0;
    {addr, wdata, img_data, src_pixel, rtn_addr} = '0;
    {clip_lx, clip_ty, clip_rx, clip_by, sclip_rx, sclip_by} = '0;
    slow = 1'b1;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk_xfer(1'b1);
    for (int i = 0; i < 6; i++) reg_wr(XO[i], XV[i]);
    chk_xfer(1'b0);
    {clip_lx, clip_ty, clip_rx} <= {CV[0], CV[1], CV[2]};
    {clip_by, sclip_rx, sclip_by} <= {CV[3], CV[4], CV[5]};
    rtn_addr <= RTN;
    clip_load <= 1'b1;
    rtn_load <= 1'b1;
    @(posedge clk);
    clip_load <= 1'b0;
    rtn_load <= 1'b0;
    reg_wr(`CRT_OFS_UCLIP_LX, 16'h1111);
    reg_wr(`CRT_OFS_RTN_HI, {9'h000, RTN[21:15]});
    chk_state();
    chk_rd(11'h7FE, 16'h0000, 16'hFFFF);
    $display("test registers done");
    reg_wr(`CRT_OFS_XFER_CTRL, 16'h0001);
    @(negedge clk);
    `CHK("dma_req", 1'b1, dma_req)
    send_words(3, {XV[0][6:0], XV[1][15:1]}, 1'b1);
    @(posedge clk);
    @(negedge clk);
    `CHK("dma_req", 1'b0, dma_req)
    @(posedge clk);
    chk_rd(`CRT_OFS_XFER_CTRL, 16'h0000, 16'h0003);
    chk_xfer(1'b0);
    $display("test dma done");
    slow <= 1'b0;
    reg_wr(`CRT_OFS_XFER_CTRL, 16'h0007);
    send_words(2, {XV[2][6:0], XV[3][15:1]}, 1'b0);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
    chk_rd(`CRT_OFS_XFER_CTRL, 16'h0000, 16'h001F);
    chk_xfer(1'b0);
    $display("test image done");
    reg_wr(`CRT_OFS_COLOR_OFS, 16'h3F9D);
    chk_rd(`CRT_OFS_COLOR_OFS, 16'h3F9D, 16'hFFFF);
    reg_wr(`CRT_OFS_XFER_CTRL, 16'h0060);
    src_pixel <= 16'hF054;
    @(posedge clk);
    @(negedge clk);
    `CHK("pixel_out", 16'hF811, pixel_out)
    @(posedge clk);
    reg_wr(`CRT_OFS_COLOR_OFS, 16'hC000);
    @(negedge clk);
    `CHK("pixel_out", 16'hB054, pixel_out)
    @(posedge clk);
    reg_wr(`CRT_OFS_XFER_CTRL, 16'h0000);
    $display("test colour done");
    do_reset();
    chk_xfer(1'b1);
    chk_state();
    $display("test reset done");
    end_of_test();
  end
endmodule
